// File: hw/dtmc_pkg.sv
// Package: register map, field layout and reset values of the dual timer
package dtmc_pkg;
	// Printed register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL    = 8'h88;
	localparam logic [7:0] IDX_MODE    = 8'h89;
	localparam logic [7:0] IDX_T0_LOW  = 8'h8a;
	localparam logic [7:0] IDX_T1_LOW  = 8'h8b;
	localparam logic [7:0] IDX_T0_HIGH = 8'h8c;
	localparam logic [7:0] IDX_T1_HIGH = 8'h8d;
	localparam logic [7:0] IDX_PRESC   = 8'h8e;
	localparam logic [7:0] IDX_IRQCFG  = 8'h8f;
	localparam logic [7:0] IDX_STAT    = 8'h90;
	localparam logic [7:0] IDX_EN      = 8'h91;
	localparam logic [7:0] IDX_CLR     = 8'h92;
	localparam int         ADDR_W      = 12;

	// Control register bit positions
	localparam int CTRL_RUN0  = 0;
	localparam int CTRL_RUN1  = 1;
	localparam int CTRL_FLAG0 = 4;
	localparam int CTRL_FLAG1 = 5;

	// Prescale choice and polarity bit positions (timer 0 / timer 1)
	localparam int SEL_T0 = 0;
	localparam int SEL_T1 = 1;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_BITS = 2'h0;

	// Default prescaler division
	localparam int PRESCALE_DIV = 12;

	// Mode field encodings
	localparam logic [1:0] MODE_13BIT  = 2'h0;
	localparam logic [1:0] MODE_16BIT  = 2'h1;
	localparam logic [1:0] MODE_RELOAD = 2'h2;
	localparam logic [1:0] MODE_SPLIT  = 2'h3;

	// Layout of the mode select register
	typedef struct packed {
		logic       timer1_gate;
		logic       timer1_count_select;
		logic [1:0] timer1_mode_field;
		logic       timer0_gate;
		logic       timer0_count_select;
		logic [1:0] timer0_mode_field;
	} dtmc_mode_t;

	// One timer's count pair
	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} dtmc_count_t;
endpackage : dtmc_pkg

// File: hw/dtmc_top.sv
// Dual counter/timer with mode control, gating and split mode, APB slave
//
// Overview of operation
// - Timer 0 mode 3 splits into two 8-bit counters
// - Low byte uses timer 0 run, select, gate, flag
// - Low byte counts clock or external pin
// - High byte counts only system or prescaled clock
// - High byte runs on timer1_run, sets timer 1 flag
// - Split: timer 1 no pin clocking, no flag
// - Split: timer 1 overflow pulse still output
// - Split: timer 1 runs unless mode 3 or its gate is closed
// - Timer 1 modes: 13, 16, reload, inactive
// - Timer 0 modes: 13, 16, reload, split
// - Timer 1 gate needs ext_irq1 at polarity
// - Timer 0 gate needs ext_irq0 at polarity
// - Timer 1 counts prescale clock or pin falls
// - Timer 0 counts prescale clock or pin falls
// - Timer 0 low byte readable, writable, resets zero
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
module dtmc_top #(
	parameter int PRESCALE_DIV = dtmc_pkg::PRESCALE_DIV
) (
	// Clock, reset and enable
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      ce,
	// APB slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [dtmc_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// External pins
	input  wire logic                      timer0_ext_count_pin,
	input  wire logic                      timer1_ext_count_pin,
	input  wire logic                      ext_irq0_line,
	input  wire logic                      ext_irq1_line,
	// Event outputs
	output logic                           timer1_overflow_pulse,
	output logic                           irq
);
	// Register map, one byte in bits 7:0 of each word:
	//   Control: run bits 1:0, overflow flags 5:4
	//   Mode select: gate, count select, mode per timer
	//   Count bytes: low and high byte of each timer
	//   Prescale choice: 1 system clock, 0 prescaled tick
	//   Gate polarity: line must equal this bit to pass
	//   Status: sticky flag-set events, cleared by write-one to the clear register
	//   Enable: mask for the level interrupt
	// Anything else answers with pslverr and ignores writes
	// Register state
	dtmc_pkg::dtmc_mode_t  mode_r;          // Mode select register
	dtmc_pkg::dtmc_count_t t0_r;            // Timer 0 count
	dtmc_pkg::dtmc_count_t t1_r;            // Timer 1 count
	logic                  run0_r;          // timer0_run
	logic                  run1_r;          // timer1_run
	logic                  flag0_r;         // timer0_overflow_flag
	logic                  flag1_r;         // timer1_overflow_flag
	logic [1:0]            presc_sel_r;     // Prescale choices
	logic [1:0]            pol_r;           // ext_irq polarities
	logic [1:0]            stat_r;          // Sticky interrupt status
	logic [1:0]            en_r;            // Interrupt enables
	logic [1:0]            pin_prev_r;      // Previous pin levels
	logic [7:0]            pre_cnt_r;       // Prescaler counter
	logic                  ovf1_pulse_r;    // Registered timer 1 overflow

	// Local carrier for one step: overflow plus both bytes
	// Count step result: overflow, high, low
	typedef struct packed {
		logic       ovf;
		logic [7:0] high;
		logic [7:0] low;
	} dtmc_step_t;

	// Split mode is handled beside this function because its
	// two bytes tick on different enables; keeping the paths
	// apart keeps each of them simple.
	// One count step for modes 0..2; mode 3 holds the count
	function automatic dtmc_step_t dtmc_step(
		input logic [1:0]            mode,
		input dtmc_pkg::dtmc_count_t cur,
		input logic                  tick
	);
		dtmc_step_t r;
		logic [13:0] s13;
		logic [16:0] s16;
		logic [8:0]  s8;
		r   = '{ovf: 1'b0, high: cur.high, low: cur.low};
		s13 = {1'b0, cur.high, cur.low[4:0]} + 14'h0001;
		s16 = {1'b0, cur.high, cur.low} + 17'h00001;
		s8  = {1'b0, cur.low} + 9'h001;
		// No tick: count stays as it is, overflow stays low
		if (tick) begin
			case (mode)
				dtmc_pkg::MODE_13BIT: begin
					// Upper three low bits are left alone
					r.high = s13[12:5];
					r.low  = {cur.low[7:5], s13[4:0]};
					r.ovf  = s13[13];
				end
				dtmc_pkg::MODE_16BIT: begin
					r.high = s16[15:8];
					r.low  = s16[7:0];
					r.ovf  = s16[16];
				end
				dtmc_pkg::MODE_RELOAD: begin
					// Reload low byte from high byte
					r.low = s8[8] ? cur.high : s8[7:0];
					r.ovf = s8[8];
				end
				default: begin
					r.ovf = 1'b0;
				end
			endcase
		end
		return r;
	endfunction : dtmc_step

	// The access phase is answered with no wait state; ce low
	// holds pready low so a frozen block cannot lose a write.
	// Only byte lane 7:0 carries data.
	// Bus decode
	wire [9:0] word_idx   = paddr[dtmc_pkg::ADDR_W-1:2];
	wire       acc        = psel & penable & ce;
	wire       wr         = acc & pwrite;
	wire       hit_ctrl   = word_idx == {2'h0, dtmc_pkg::IDX_CTRL};
	wire       hit_mode   = word_idx == {2'h0, dtmc_pkg::IDX_MODE};
	wire       hit_t0l    = word_idx == {2'h0, dtmc_pkg::IDX_T0_LOW};
	wire       hit_t1l    = word_idx == {2'h0, dtmc_pkg::IDX_T1_LOW};
	wire       hit_t0h    = word_idx == {2'h0, dtmc_pkg::IDX_T0_HIGH};
	wire       hit_t1h    = word_idx == {2'h0, dtmc_pkg::IDX_T1_HIGH};
	wire       hit_presc  = word_idx == {2'h0, dtmc_pkg::IDX_PRESC};
	wire       hit_irqcfg = word_idx == {2'h0, dtmc_pkg::IDX_IRQCFG};
	wire       hit_stat   = word_idx == {2'h0, dtmc_pkg::IDX_STAT};
	wire       hit_en     = word_idx == {2'h0, dtmc_pkg::IDX_EN};
	wire       hit_clr    = word_idx == {2'h0, dtmc_pkg::IDX_CLR};
	wire       hit_any    = hit_ctrl | hit_mode | hit_t0l | hit_t1l
	                      | hit_t0h | hit_t1h | hit_presc | hit_irqcfg
	                      | hit_stat | hit_en | hit_clr;
	wire [7:0] wb         = pwdata[7:0];

	// Error answer ignores ce; it follows the access phase and address only
	// Always ready while enabled; a frozen block stalls the bus
	assign pready  = ce;
	assign pslverr = psel & penable & ~hit_any;

	// Read data is combinational from registers, so it stands
	// as long as the address does; no read has side effects.
	// Read mux; the clear register reads as zero
	wire [7:0] ctrl_rd = {2'h0, flag1_r, flag0_r, 2'h0, run1_r, run0_r};
	assign prdata = {24'h0,
		hit_ctrl   ? ctrl_rd :
		hit_mode   ? mode_r :
		hit_t0l    ? t0_r.low :
		hit_t1l    ? t1_r.low :
		hit_t0h    ? t0_r.high :
		hit_t1h    ? t1_r.high :
		hit_presc  ? {6'h0, presc_sel_r} :
		hit_irqcfg ? {6'h0, pol_r} :
		hit_stat   ? {6'h0, stat_r} :
		hit_en     ? {6'h0, en_r} : 8'h00};

	// The prescaler runs free and is shared by both timers and
	// the split high byte, so their prescaled ticks line up.
	// A new prescale choice takes effect in the next cycle.
	// Prescaled clock tick
	wire pre_tick = pre_cnt_r == 8'(PRESCALE_DIV - 1);
	// Timebase: 1 selects system clock, 0 the prescaled clock
	wire base0 = presc_sel_r[dtmc_pkg::SEL_T0] | pre_tick;
	wire base1 = presc_sel_r[dtmc_pkg::SEL_T1] | pre_tick;

	// Pins are taken as synchronous; an edge is a high sample
	// followed by a low one. History resets low, so an idle
	// high pin gives no false edge after reset.
	// Falling edges of external count pins
	wire fall0 = pin_prev_r[0] & ~timer0_ext_count_pin;
	wire fall1 = pin_prev_r[1] & ~timer1_ext_count_pin;

	// Gate off: the run bit alone decides. Gate on: the line
	// must also match its polarity bit in every cycle.
	// Gating by external interrupt lines at configured polarity
	wire gate_ok0 = ~mode_r.timer0_gate
	              | (ext_irq0_line == pol_r[dtmc_pkg::SEL_T0]);
	wire gate_ok1 = ~mode_r.timer1_gate
	              | (ext_irq1_line == pol_r[dtmc_pkg::SEL_T1]);

	// Split follows the mode field at once; no handshake is
	// needed because all state shares one clock.
	// Split mode of timer 0
	wire split = mode_r.timer0_mode_field == dtmc_pkg::MODE_SPLIT;

	// In split mode the same tick drives the low byte alone
	// Timer 0 (or its low byte in split) run and tick
	wire src0  = mode_r.timer0_count_select ? fall0 : base0;
	wire tick0 = run0_r & gate_ok0 & src0;

	// The high byte ignores gate and count select: timer only
	// Split high byte: timer only, enabled by timer1_run
	wire tick0h = split & run1_r & base0;

	// While timer 0 is split, timer 1 loses its run bit to the
	// high byte, so only mode 3 or its gate stops it; its pin input and its
	// flag are cut off but the overflow pulse stays alive.
	// Timer 1: run bit taken over in split, mode 3 stops it
	wire t1_go   = split ? 1'b1 : run1_r;
	wire src1    = (mode_r.timer1_count_select & ~split)
	               ? fall1 : base1;
	wire tick1   = t1_go & gate_ok1 & src1
	             & (mode_r.timer1_mode_field != dtmc_pkg::MODE_SPLIT);

	// Both timers share the same step logic; only the tick and
	// the mode field differ.
	// Step results
	dtmc_step_t s0;
	dtmc_step_t s1;
	assign s0 = dtmc_step(mode_r.timer0_mode_field, t0_r, tick0);
	assign s1 = dtmc_step(mode_r.timer1_mode_field, t1_r, tick1);

	// In split mode the step result is ignored for timer 0;
	// each byte wraps on its own and only the low byte may
	// raise timer 0's flag.
	// Split counters: each byte an independent 8-bit counter
	wire [8:0] sl = {1'b0, t0_r.low}  + 9'h001;
	wire [8:0] sh = {1'b0, t0_r.high} + 9'h001;
	wire       ovf_lo = split & tick0 & sl[8];
	wire       ovf_hi = tick0h & sh[8];

	// Timer 1's own overflow is dropped in split; the high
	// byte's overflow takes its flag instead.
	// Flag set events
	wire set0 = split ? ovf_lo : s0.ovf;
	wire set1 = split ? ovf_hi : s1.ovf;

	// Split mode bypasses the step result for both bytes of
	// timer 0 and uses the two 8-bit incrementers instead.
	// Next count values, bus writes win over counting
	wire [7:0] t0l_cnt = split ? (tick0 ? sl[7:0] : t0_r.low) : s0.low;
	wire [7:0] t0h_cnt = split ? (tick0h ? sh[7:0] : t0_r.high) : s0.high;
	dtmc_pkg::dtmc_count_t t0_nxt;
	dtmc_pkg::dtmc_count_t t1_nxt;
	assign t0_nxt.low  = (wr & hit_t0l) ? wb : t0l_cnt;
	assign t0_nxt.high = (wr & hit_t0h) ? wb : t0h_cnt;
	assign t1_nxt.low  = (wr & hit_t1l) ? wb : s1.low;
	assign t1_nxt.high = (wr & hit_t1h) ? wb : s1.high;

	// A flag written to 1 by software is set as well; a write
	// of 0 clears it unless hardware sets it in the same cycle,
	// so no overflow is ever lost to a racing clear.
	// Flags: hardware set wins over a software clear
	wire wr_ctrl   = wr & hit_ctrl;
	wire flag0_nxt = set0 | (wr_ctrl ? wb[dtmc_pkg::CTRL_FLAG0] : flag0_r);
	wire flag1_nxt = set1 | (wr_ctrl ? wb[dtmc_pkg::CTRL_FLAG1] : flag1_r);

	// Interrupt status: sticky, set wins over clear
	wire [1:0] clr_mask = (wr & hit_clr) ? wb[1:0] : 2'h0;
	wire [1:0] stat_nxt = {set1, set0} | (stat_r & ~clr_mask);

	// Status bits are independent of the flags: clearing a flag
	// in the control register leaves the status bit standing.
	// Level interrupt while any enabled status bit is set
	assign irq = |(stat_r & en_r);

	// Overflow pulse of timer 1 for serial rate and conversion use
	assign timer1_overflow_pulse = ovf1_pulse_r;

	// Counting and bus writes share one register; writes win
	// so software can preload a running timer.
	// Counters and count registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			t0_r <= {dtmc_pkg::RST_BYTE, dtmc_pkg::RST_BYTE};
			t1_r <= {dtmc_pkg::RST_BYTE, dtmc_pkg::RST_BYTE};
		end else if (ce) begin
			t0_r <= t0_nxt;
			t1_r <= t1_nxt;
		end
	end

	// Run bits change only on a control write; flags follow
	// their next-value logic in every enabled cycle.
	// Control bits and flags
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			run0_r  <= 1'b0;
			run1_r  <= 1'b0;
			flag0_r <= 1'b0;
			flag1_r <= 1'b0;
		end else if (ce) begin
			if (wr_ctrl) begin
				run0_r <= wb[dtmc_pkg::CTRL_RUN0];
				run1_r <= wb[dtmc_pkg::CTRL_RUN1];
			end
			flag0_r <= flag0_nxt;
			flag1_r <= flag1_nxt;
		end
	end

	// Mode changes take effect at the next count step; a split
	// entered mid-count keeps both bytes as they stand.
	// Configuration registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_r      <= dtmc_pkg::RST_BYTE;
			presc_sel_r <= dtmc_pkg::RST_BITS;
			pol_r       <= dtmc_pkg::RST_BITS;
			en_r        <= dtmc_pkg::RST_BITS;
		end else if (ce && wr) begin
			if (hit_mode) begin
				mode_r <= wb;
			end
			if (hit_presc) begin
				presc_sel_r <= wb[1:0];
			end
			if (hit_irqcfg) begin
				pol_r <= wb[1:0];
			end
			if (hit_en) begin
				en_r <= wb[1:0];
			end
		end
	end

	// The pulse is registered so it is clean for serial rate
	// and conversion users; it lags the overflow by one cycle.
	// Interrupt status, prescaler, pin history and overflow pulse
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stat_r       <= dtmc_pkg::RST_BITS;
			pre_cnt_r    <= dtmc_pkg::RST_BYTE;
			pin_prev_r   <= dtmc_pkg::RST_BITS;
			ovf1_pulse_r <= 1'b0;
		end else if (ce) begin
			stat_r       <= stat_nxt;
			pre_cnt_r    <= pre_tick ? 8'h00 : pre_cnt_r + 8'h01;
			pin_prev_r   <= {timer1_ext_count_pin, timer0_ext_count_pin};
			ovf1_pulse_r <= s1.ovf;
		end
	end
endmodule : dtmc_top

// File: tb/dtmc_props.sv
// Checker: bus answer and interrupt output properties of the timers
`timescale 1ns/100ps
module dtmc_props #(
	parameter int PRESCALE_DIV = 12
) (
	// Clock, reset and bus
	input wire logic                        clk, rst_n, ce,
	input wire logic                        psel, penable, pwrite,
	input wire logic [dtmc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                 pwdata, prdata,
	input wire logic                        pready, pslverr,
	// Pins and events
	input wire logic                        timer0_ext_count_pin,
	input wire logic                        timer1_ext_count_pin,
	input wire logic                        ext_irq0_line, ext_irq1_line,
	input wire logic                        timer1_overflow_pulse, irq
);
	// Access phase and word index decode
	wire       acc  = psel && penable;
	wire [9:0] widx = paddr[11:2];
	wire       lo_ok = widx >= {2'h0, dtmc_pkg::IDX_CTRL};
	wire       mapped = lo_ok && widx <= {2'h0, dtmc_pkg::IDX_CLR};
	wire       rd_clr = acc && !pwrite && widx == {2'h0, dtmc_pkg::IDX_CLR};
	wire       en_adr = widx == {2'h0, dtmc_pkg::IDX_EN};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// All-zero enable mask taken at this edge
	sequence s_mask_off;
		acc && ce && pwrite && en_adr && pwdata[7:0] == 8'h00;
	endsequence
	a_ready_ce: assert property (pready == ce)
		else $error("pready does not follow ce");
	a_err_unmapped: assert property (acc && !mapped |-> pslverr)
		else $error("unmapped access without pslverr");
	a_err_mapped: assert property (acc && mapped |-> !pslverr)
		else $error("mapped access with pslverr");
	a_err_access: assert property (pslverr |-> acc)
		else $error("pslverr outside access phase");
	a_read_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_clear_zero: assert property (rd_clr |-> prdata == 32'h0)
		else $error("clear register reads nonzero");
	a_irq_masked: assert property (s_mask_off |=> !irq)
		else $error("irq high with empty mask");
	a_ce_freeze: assert property (!ce |=> $stable(irq) && $stable(timer1_overflow_pulse))
		else $error("outputs moved while ce low");
endmodule : dtmc_props
bind dtmc_top dtmc_props #(.PRESCALE_DIV(PRESCALE_DIV)) i_props (
	.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr),
	.timer0_ext_count_pin(timer0_ext_count_pin),
	.timer1_ext_count_pin(timer1_ext_count_pin),
	.ext_irq0_line(ext_irq0_line), .ext_irq1_line(ext_irq1_line),
	.timer1_overflow_pulse(timer1_overflow_pulse), .irq(irq));

// File: tb/dual_timer_mode_control_tb.sv
// Testbench: register, pin counting, reload, split and interrupt scenarios
`timescale 1ns/100ps
module dual_timer_mode_control_tb;
	logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, err;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pin0 = 1'b1, pin1 = 1'b1, irq0 = 1'b1, irq1 = 1'b0;
	logic        pready, pslverr, pulse, irq;
	int          miscompares = 0, checks_done = 0;
	// Short prescale count keeps the run brief
	dtmc_top #(.PRESCALE_DIV(2)) i_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer0_ext_count_pin(pin0),
		.timer1_ext_count_pin(pin1), .ext_irq0_line(irq0),
		.ext_irq1_line(irq1), .timer1_overflow_pulse(pulse), .irq(irq));
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// One transfer; held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] idx, d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {2'h0, idx, 2'h0};
		pwdata  <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] idx, d);
		apb(1'b1, idx, d);
	endtask : wr
	task automatic rc(input logic [7:0] idx, e);
		apb(1'b0, idx, 8'h00);
		chk($sformatf("reg %h", idx), q, {24'h0, e});
	endtask : rc
	// Falling edges on one count pin, pins idle high
	task automatic edges(input logic t, input int n);
		repeat (n) begin
			@(posedge clk);
			if (t) pin1 <= 1'b0;
			else pin0 <= 1'b0;
			repeat (2) @(posedge clk);
			pin0 <= 1'b1;
			pin1 <= 1'b1;
			@(posedge clk);
		end
	endtask : edges
	task automatic t_regs;
		rc(dtmc_pkg::IDX_T0_LOW, 8'h00);
		rc(dtmc_pkg::IDX_CTRL, 8'h00);
		wr(dtmc_pkg::IDX_T0_LOW, 8'ha5);
		rc(dtmc_pkg::IDX_T0_LOW, 8'ha5);
		apb(1'b0, 8'h10, 8'h00);
		chk("pslverr", err, 32'h1);
		apb(1'b0, dtmc_pkg::IDX_CLR, 8'h00);
		chk("clear read", q, 32'h0);
	endtask : t_regs
	// Gate closed while line differs from polarity, then pin counting
	task automatic t_pins;
		wr(dtmc_pkg::IDX_MODE, 8'h0d);
		wr(dtmc_pkg::IDX_T0_LOW, 8'h00);
		wr(dtmc_pkg::IDX_CTRL, 8'h01);
		edges(1'b0, 2);
		rc(dtmc_pkg::IDX_T0_LOW, 8'h00);
		irq0 <= 1'b0;
		edges(1'b0, 3);
		rc(dtmc_pkg::IDX_T0_LOW, 8'h03);
		wr(dtmc_pkg::IDX_MODE, 8'h50);
		wr(dtmc_pkg::IDX_T1_LOW, 8'h00);
		wr(dtmc_pkg::IDX_CTRL, 8'h02);
		edges(1'b1, 2);
		rc(dtmc_pkg::IDX_T1_LOW, 8'h02);
	endtask : t_pins
	// Reload on overflow, flag, status and interrupt path
	task automatic t_reload;
		wr(dtmc_pkg::IDX_MODE, 8'h06);
		wr(dtmc_pkg::IDX_T0_HIGH, 8'hf0);
		wr(dtmc_pkg::IDX_T0_LOW, 8'hfe);
		wr(dtmc_pkg::IDX_CTRL, 8'h01);
		edges(1'b0, 3);
		rc(dtmc_pkg::IDX_T0_LOW, 8'hf1);
		rc(dtmc_pkg::IDX_CTRL, 8'h11);
		rc(dtmc_pkg::IDX_STAT, 8'h01);
		wr(dtmc_pkg::IDX_EN, 8'h01);
		@(posedge clk);
		chk("irq", irq, 32'h1);
		wr(dtmc_pkg::IDX_EN, 8'h00);
		@(posedge clk);
		chk("irq", irq, 32'h0);
		wr(dtmc_pkg::IDX_CLR, 8'h01);
		rc(dtmc_pkg::IDX_STAT, 8'h00);
		ce <= 1'b0;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		rc(dtmc_pkg::IDX_T0_LOW, 8'hf1);
	endtask : t_reload
	// Rollover of the 13-bit count leaves low bits 7:5 alone
	task automatic t_13bit;
		wr(dtmc_pkg::IDX_MODE, 8'h04);
		wr(dtmc_pkg::IDX_T0_HIGH, 8'hff);
		wr(dtmc_pkg::IDX_T0_LOW, 8'hff);
		wr(dtmc_pkg::IDX_CTRL, 8'h01);
		edges(1'b0, 1);
		rc(dtmc_pkg::IDX_T0_HIGH, 8'h00);
		rc(dtmc_pkg::IDX_T0_LOW, 8'he0);
		rc(dtmc_pkg::IDX_CTRL, 8'h11);
	endtask : t_13bit
	// Split timer 0; timer 1 stopped by mode, then run by mode
	task automatic t_split;
		int i;
		wr(dtmc_pkg::IDX_PRESC, 8'h01);
		wr(dtmc_pkg::IDX_MODE, 8'h77);
		wr(dtmc_pkg::IDX_T0_LOW, 8'h00);
		wr(dtmc_pkg::IDX_T0_HIGH, 8'hfe);
		wr(dtmc_pkg::IDX_T1_LOW, 8'h00);
		wr(dtmc_pkg::IDX_CTRL, 8'h03);
		edges(1'b0, 2);
		edges(1'b1, 2);
		rc(dtmc_pkg::IDX_T0_LOW, 8'h02);
		rc(dtmc_pkg::IDX_CTRL, 8'h23);
		rc(dtmc_pkg::IDX_T1_LOW, 8'h00);
		wr(dtmc_pkg::IDX_CTRL, 8'h01);
		wr(dtmc_pkg::IDX_PRESC, 8'h03);
		wr(dtmc_pkg::IDX_T1_HIGH, 8'hff);
		wr(dtmc_pkg::IDX_T1_LOW, 8'hf0);
		wr(dtmc_pkg::IDX_MODE, 8'h17);
		for (i = 0; i < 300 && pulse !== 1'b1; i++) @(posedge clk);
		chk("pulse", pulse, 32'h1);
		rc(dtmc_pkg::IDX_CTRL, 8'h01);
	endtask : t_split
	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	// Hang guard, far beyond the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		give_verdict();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_pins();
		t_reload();
		t_13bit();
		t_split();
		give_verdict();
	end
endmodule : dual_timer_mode_control_tb
